/* common/uws_map.svh */
`ifndef UWS_MAP_SVH
`define UWS_MAP_SVH

// Primary opcode field and its two decoded values
`define UWS_OP_MSB 31
`define UWS_OP_LSB 26
`define UWS_OP_LEFT 6'h2A
`define UWS_OP_RIGHT 6'h2E

// Remaining instruction fields
`define UWS_BASE_MSB 25
`define UWS_BASE_LSB 21
`define UWS_SRC_MSB 20
`define UWS_SRC_LSB 16
`define UWS_DISP_MSB 15
`define UWS_DISP_LSB 0

// Widths
`define UWS_VA_W 64
`define UWS_PA_W 32
`define UWS_DISP_W 16
`define UWS_BUS_W 64

// Full word access type; right store asks for this minus the byte index
`define UWS_WORD_TYPE 2'h3

// Shift step per byte lane
`define UWS_BYTE_BITS 8

`endif

/* common/uws_pkg.sv */
`include "uws_map.svh"
`default_nettype none

package uws_pkg;

    typedef enum logic [1:0] {
        UWS_IDLE = 2'b00,
        UWS_XLAT = 2'b01,
        UWS_STORE = 2'b10
    } uws_state_t;

    typedef enum logic {
        UWS_KIND_LEFT = 1'b0,
        UWS_KIND_RIGHT = 1'b1
    } uws_kind_t;

    typedef struct packed {
        logic core_msb_first_flag;
        logic memory_msb_first_flag;
        logic swap_byte_order_flag;
    } uws_order_t;

    typedef struct packed {
        logic [`UWS_PA_W-1:0] addr;
        logic [1:0] acc_type;
        logic [`UWS_BUS_W-1:0] data;
    } uws_store_req_t;

endpackage

`default_nettype wire

/* src/uws_addr_gen.sv */
`include "uws_map.svh"
`default_nettype none

// Base plus sign-extended displacement
module uws_addr_gen (
    input wire logic [`UWS_VA_W-1:0] base_value,
    input wire logic [`UWS_DISP_W-1:0] displacement,
    output logic [`UWS_VA_W-1:0] virtual_byte_address
);
    wire [`UWS_VA_W-1:0] disp_ext;

    assign disp_ext = {{(`UWS_VA_W-`UWS_DISP_W){displacement[`UWS_DISP_W-1]}}, displacement};
    // Any byte may be addressed; no alignment check is made
    assign virtual_byte_address = base_value + disp_ext;
endmodule

`default_nettype wire

/* src/uws_lane_mux.sv */
`include "uws_map.svh"
`default_nettype none

// Byte index, access type, physical offset and bus data for one partial store
module uws_lane_mux
    import uws_pkg::*;
(
    input wire uws_pkg::uws_kind_t kind,
    input wire uws_pkg::uws_order_t order,
    input wire logic [2:0] va_lo,
    input wire logic [31:0] src_word,
    input wire logic [`UWS_PA_W-1:0] phys_addr,
    output uws_pkg::uws_store_req_t req
);
    wire [1:0] byte_idx;
    wire upper_half;
    wire [4:0] left_shift;
    wire [4:0] right_shift;
    wire [31:0] left_word;
    wire [31:0] right_word;
    wire [31:0] lane_word;
    wire [2:0] pa_lo_swapped;
    wire clear_lo;
    wire [`UWS_PA_W-1:0] req_addr;
    wire [1:0] req_type;
    wire [`UWS_BUS_W-1:0] req_data;

    assign byte_idx = va_lo[1:0] ^ {2{order.core_msb_first_flag}};
    assign upper_half = va_lo[2] ^ order.core_msb_first_flag;

    // Left: top bytes end at the lane index; right: low bytes start there
    assign left_shift = 5'(`UWS_BYTE_BITS * (3 - byte_idx));
    assign right_shift = 5'(`UWS_BYTE_BITS * byte_idx);
    assign left_word = src_word >> left_shift;
    assign right_word = src_word << right_shift;
    assign lane_word = (kind == UWS_KIND_LEFT) ? left_word : right_word;

    // Unused half stays zero so access type and address alone pick the lanes
    assign req_data = upper_half ? {lane_word, 32'h0000_0000} : {32'h0000_0000, lane_word};

    assign req_type = (kind == UWS_KIND_LEFT) ? byte_idx : (`UWS_WORD_TYPE - byte_idx);

    assign pa_lo_swapped = phys_addr[2:0] ^ {3{order.swap_byte_order_flag}};
    assign clear_lo = (kind == UWS_KIND_LEFT) ? !order.memory_msb_first_flag
                                               : order.memory_msb_first_flag;
    assign req_addr = {phys_addr[`UWS_PA_W-1:3], pa_lo_swapped[2],
                       clear_lo ? 2'b00 : pa_lo_swapped[1:0]};
    // One driver for the whole request word
    assign req = {req_addr, req_type, req_data};
endmodule

`default_nettype wire

/* src/uws_top.sv */
// Operation
// - Left store decoded from opcode 101010
// - Address is base plus sign-extended displacement
// - Only the word holding start byte changes
// - Left: top source byte at address, downward
// - Right: low source byte at address, upward
// - No alignment address error ever raised
// - Left, lsb-first memory: clear address bits 1:0
// - Right, msb-first memory: clear address bits 1:0
// - Bus half picked by addr bit2 xor core
// - Left type is byte index, data shifted down
// - Right type three minus index, data shifted up
// - Left offsets follow the little-core table
// - Right offsets follow the little-core table
`include "uws_map.svh"
`default_nettype none

module uws_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [`UWS_VA_W-1:0] base_value,
    input wire logic [`UWS_VA_W-1:0] source_value,
    input wire uws_pkg::uws_order_t order_in,
    output logic instr_ready,
    output logic xlat_valid,
    output logic [`UWS_VA_W-1:0] xlat_virtual_byte_address,
    input wire logic xlat_ack,
    input wire logic [`UWS_PA_W-1:0] xlat_paddr,
    output logic mem_valid,
    output uws_pkg::uws_store_req_t mem_req,
    input wire logic mem_ready
);
    import uws_pkg::*;

    // Reset release through two flops
    logic rst_meta_b;
    logic rst_sync_b;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    function automatic logic is_partial_store(input logic [5:0] op);
        is_partial_store = (op == `UWS_OP_LEFT) || (op == `UWS_OP_RIGHT);
    endfunction

    uws_state_t state;
    uws_state_t next_state;
    uws_kind_t kind;
    uws_order_t order;
    logic [2:0] va_lo;
    logic [31:0] src_word;

    wire [5:0] opcode;
    wire [`UWS_DISP_W-1:0] displacement;
    wire [`UWS_VA_W-1:0] virtual_byte_address_calc;
    wire take;
    wire xlat_done;
    wire store_done;
    wire uws_kind_t kind_calc;
    uws_store_req_t req_calc;

    assign opcode = instr_word[`UWS_OP_MSB:`UWS_OP_LSB];
    assign displacement = instr_word[`UWS_DISP_MSB:`UWS_DISP_LSB];
    // Other opcodes are ignored, never half-started
    assign take = instr_valid && instr_ready && is_partial_store(opcode);
    assign kind_calc = (opcode == `UWS_OP_LEFT) ? UWS_KIND_LEFT : UWS_KIND_RIGHT;
    assign xlat_done = xlat_valid && xlat_ack;
    assign store_done = mem_valid && mem_ready;

    uws_addr_gen u_addr_gen (
        .base_value(base_value),
        .displacement(displacement),
        .virtual_byte_address(virtual_byte_address_calc)
    );

    uws_lane_mux u_lane_mux (
        .kind(kind),
        .order(order),
        .va_lo(va_lo),
        .src_word(src_word),
        .phys_addr(xlat_paddr),
        .req(req_calc)
    );

    always_comb begin
        next_state = state;
        case (state)
            UWS_IDLE: begin
                if (take) begin
                    next_state = UWS_XLAT;
                end
            end
            UWS_XLAT: begin
                if (xlat_ack) begin
                    next_state = UWS_STORE;
                end
            end
            UWS_STORE: begin
                if (mem_ready) begin
                    next_state = UWS_IDLE;
                end
            end
            default: begin
                next_state = UWS_IDLE;
            end
        endcase
    end

    wire next_ready;
    wire next_xlat_valid;
    wire next_mem_valid;

    assign next_ready = (next_state == UWS_IDLE);
    assign next_xlat_valid = (next_state == UWS_XLAT);
    assign next_mem_valid = (next_state == UWS_STORE);

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= UWS_IDLE;
            instr_ready <= 1'b0;
            xlat_valid <= 1'b0;
            mem_valid <= 1'b0;
        end else begin
            state <= next_state;
            instr_ready <= next_ready;
            xlat_valid <= next_xlat_valid;
            mem_valid <= next_mem_valid;
        end
    end

    // Operands held from issue so the pipeline may move on meanwhile
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            kind <= UWS_KIND_LEFT;
            order <= '0;
            va_lo <= 3'h0;
            src_word <= 32'h0000_0000;
            xlat_virtual_byte_address <= '0;
        end else if (take) begin
            kind <= kind_calc;
            order <= order_in;
            va_lo <= virtual_byte_address_calc[2:0];
            src_word <= source_value[31:0];
            xlat_virtual_byte_address <= virtual_byte_address_calc;
        end
    end

    // One access per instruction, confined to one aligned word
    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mem_req <= '0;
        end else if (xlat_done) begin
            mem_req <= req_calc;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_sync_b);

    wire [1:0] held_idx;
    wire held_upper;
    wire [31:0] bus_word;
    wire [4:0] held_left_shift;
    wire [4:0] held_right_shift;

    assign held_idx = va_lo[1:0] ^ {2{order.core_msb_first_flag}};
    assign held_upper = va_lo[2] ^ order.core_msb_first_flag;
    assign bus_word = held_upper ? mem_req.data[63:32] : mem_req.data[31:0];
    assign held_left_shift = 5'(`UWS_BYTE_BITS * (3 - held_idx));
    assign held_right_shift = 5'(`UWS_BYTE_BITS * held_idx);

    sequence s_issue;
        instr_valid && instr_ready && is_partial_store(opcode);
    endsequence

    sequence s_xlat_wait;
        xlat_valid && !xlat_ack;
    endsequence

    sequence s_translated;
        xlat_valid && xlat_ack;
    endsequence

    sequence s_store_taken;
        mem_valid && mem_ready;
    endsequence

    wire left_store;
    wire right_store;

    assign left_store = mem_valid && (kind == UWS_KIND_LEFT);
    assign right_store = mem_valid && (kind == UWS_KIND_RIGHT);

    a_issue_only_decoded: assert property (
        xlat_valid && !$past(xlat_valid) |-> $past(is_partial_store(opcode) && instr_valid))
        else $error("translation started without a partial store opcode");

    a_issue_to_xlat: assert property (
        s_issue |=> xlat_valid && !instr_ready && xlat_virtual_byte_address == $past(virtual_byte_address_calc))
        else $error("virtual address not presented after issue");

    a_xlat_to_store: assert property (
        s_translated |=> mem_valid && !xlat_valid)
        else $error("store not issued after translation");

    a_one_store_only: assert property (
        mem_valid && mem_ready |=> !mem_valid [*2] or (instr_ready ##1 xlat_valid))
        else $error("more than one access per instruction");

    a_no_fault_path: assert property (
        s_issue |=> xlat_valid)
        else $error("partial store dropped on unaligned address");

    a_left_data: assert property (
        left_store |-> bus_word == (src_word >> held_left_shift))
        else $error("left store data misplaced");

    a_right_data: assert property (
        right_store |-> bus_word == (src_word << held_right_shift))
        else $error("right store data misplaced");

    a_half_zero: assert property (
        mem_valid |-> (held_upper ? mem_req.data[31:0] : mem_req.data[63:32]) == 32'h0000_0000)
        else $error("unused bus half not zero");

    a_left_type: assert property (
        left_store |-> mem_req.acc_type == held_idx)
        else $error("left store access type wrong");

    a_right_type: assert property (
        right_store |-> mem_req.acc_type == 2'(`UWS_WORD_TYPE - held_idx))
        else $error("right store access type wrong");

    a_left_addr_clr: assert property (
        left_store && !order.memory_msb_first_flag |-> mem_req.addr[1:0] == 2'b00)
        else $error("left store low address bits not cleared");

    a_right_addr_clr: assert property (
        right_store && order.memory_msb_first_flag |-> mem_req.addr[1:0] == 2'b00)
        else $error("right store low address bits not cleared");

    a_swap_bits: assert property (
        s_translated |=> mem_req.addr[2] == ($past(xlat_paddr[2]) ^ order.swap_byte_order_flag))
        else $error("swap flag not applied to address bit 2");

    a_left_table: assert property (
        xlat_done && kind == UWS_KIND_LEFT && !order.core_msb_first_flag
        && !order.swap_byte_order_flag && order.memory_msb_first_flag
        |=> mem_req.addr[2:0] == $past(xlat_paddr[2:0]))
        else $error("left store offset off the table");

    a_right_table: assert property (
        xlat_done && kind == UWS_KIND_RIGHT && !order.core_msb_first_flag
        && !order.swap_byte_order_flag && !order.memory_msb_first_flag
        |=> mem_req.addr[2:0] == $past(xlat_paddr[2:0]))
        else $error("right store offset off the table");

    a_store_holds: assert property (
        mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
        else $error("store request changed while stalled");

    // Handshake shape: each output stands until its answer arrives
    a_xlat_holds: assert property (
        s_xlat_wait |=> xlat_valid && $stable(xlat_virtual_byte_address))
        else $error("translation request dropped before acknowledge");

    a_virtual_byte_address_low: assert property (
        s_issue |=> va_lo == $past(virtual_byte_address_calc[2:0]))
        else $error("held low address bits differ from issue");

    a_kind_decoded: assert property (
        s_issue |=> (kind == UWS_KIND_LEFT) == ($past(opcode) == `UWS_OP_LEFT))
        else $error("store kind not taken from opcode");

    a_other_ignored: assert property (
        instr_valid && instr_ready && !is_partial_store(opcode) |=> instr_ready && !xlat_valid)
        else $error("other opcode started a store");

    a_order_held: assert property (
        s_issue |=> order == $past(order_in))
        else $error("byte order flags not held from issue");

    a_word_kept: assert property (
        s_translated |=> mem_req.addr[31:3] == $past(xlat_paddr[31:3]))
        else $error("store left the addressed word");

    // Back to idle with nothing pending, so no second access can follow
    a_store_exits: assert property (
        s_store_taken |=> instr_ready && !mem_valid)
        else $error("not idle after store accepted");

    a_idle_quiet: assert property (
        instr_ready |-> !xlat_valid && !mem_valid)
        else $error("request pending while idle");
endmodule

`default_nettype wire

/* dv/uws_mem_model.sv */
`default_nettype none

// Translation then store partner, answer delay set per operation
module uws_mem_model
    import uws_pkg::*;
#(
    parameter logic [31:0] PMAP = 32'h5A5A_5A58
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [1:0] wait_n,
    input wire logic xlat_valid,
    input wire logic [63:0] xlat_virtual_byte_address,
    output logic xlat_ack,
    output logic [31:0] xlat_paddr,
    input wire logic mem_valid,
    input wire uws_pkg::uws_store_req_t mem_req,
    output logic mem_ready,
    output logic got,
    output uws_pkg::uws_store_req_t seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            xlat_ack <= 1'b0;
            mem_ready <= 1'b0;
            cnt <= 2'h0;
            got <= 1'b0;
            xlat_paddr <= 32'h0;
            seen <= '0;
        end else begin
            xlat_ack <= 1'b0;
            mem_ready <= 1'b0;
            got <= mem_valid && mem_ready;
            // Stale address must never look valid between answers
            xlat_paddr <= ~xlat_paddr;
            if (mem_valid && mem_ready) begin
                seen <= mem_req;
            end
            if ((xlat_valid && !xlat_ack) || (mem_valid && !mem_ready)) begin
                cnt <= cnt + 2'h1;
                if (cnt == wait_n) begin
                    cnt <= 2'h0;
                    xlat_ack <= xlat_valid;
                    mem_ready <= mem_valid;
                    // Low three bits kept so lane offsets follow the address
                    xlat_paddr <= xlat_virtual_byte_address[31:0] ^ PMAP;
                end
            end
        end
    end
endmodule

`default_nettype wire

/* dv/test_unaligned_word_store.sv */
`include "uws_map.svh"
`default_nettype none

module test_unaligned_word_store;
    timeunit 1ns;
    timeprecision 1ps;
    import uws_pkg::*;
    localparam logic [31:0] PMAP = 32'h5A5A_5A58;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic instr_valid = 1'b0;
    logic [31:0] instr_word = 32'h0;
    logic [63:0] base_value = 64'h0;
    logic [63:0] source_value = 64'h0;
    uws_order_t order_in = '0;
    logic [1:0] wait_n = 2'h0;
    logic instr_ready, xlat_valid, xlat_ack, mem_valid, mem_ready, got;
    logic [63:0] xlat_virtual_byte_address;
    logic [31:0] xlat_paddr;
    uws_store_req_t mem_req, seen;
    integer seed = 15;
    integer err_total = 0;
    integer n_checks = 0;
    integer cyc = 0;
    integer i, r;

    always #4 clock = ~clock;

    uws_top DUT (.clock(clock), .rst_b(rst_b), .instr_valid(instr_valid),
        .instr_word(instr_word), .base_value(base_value), .source_value(source_value),
        .order_in(order_in), .instr_ready(instr_ready), .xlat_valid(xlat_valid),
        .xlat_virtual_byte_address(xlat_virtual_byte_address), .xlat_ack(xlat_ack), .xlat_paddr(xlat_paddr),
        .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready));

    uws_mem_model #(.PMAP(PMAP)) partner (.clock(clock), .rst_b(rst_b), .wait_n(wait_n),
        .xlat_valid(xlat_valid), .xlat_virtual_byte_address(xlat_virtual_byte_address), .xlat_ack(xlat_ack),
        .xlat_paddr(xlat_paddr), .mem_valid(mem_valid), .mem_req(mem_req),
        .mem_ready(mem_ready), .got(got), .seen(seen));

    task report_and_stop;
        $display("Counts: %0d checks, %0d mismatches", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            report_and_stop;
        end
    end

    task check(input logic [127:0] got_v, input logic [127:0] exp_v, input string what);
        n_checks = n_checks + 1;
        if (got_v !== exp_v) begin
            err_total = err_total + 1;
            $display("Error at %0t: %s seen %h expected %h", $time, what, got_v, exp_v);
        end
    endtask

    function automatic uws_store_req_t exp_req(input uws_kind_t k, input uws_order_t o,
        input logic [2:0] va, input logic [31:0] src, input logic [31:0] pa);
        uws_store_req_t q;
        logic [1:0] bi;
        logic [31:0] w;
        bi = va[1:0] ^ {2{o.core_msb_first_flag}};
        q.addr = {pa[31:3], pa[2:0] ^ {3{o.swap_byte_order_flag}}};
        if ((k == UWS_KIND_LEFT) != o.memory_msb_first_flag) begin
            q.addr[1:0] = 2'h0;
        end
        w = (k == UWS_KIND_LEFT) ? src >> (8 * (3 - bi)) : src << (8 * bi);
        q.acc_type = (k == UWS_KIND_LEFT) ? bi : 2'h3 - bi;
        q.data = (va[2] ^ o.core_msb_first_flag) ? {w, 32'h0} : {32'h0, w};
        return q;
    endfunction

    task run_op(input uws_kind_t k, input uws_order_t o, input logic [2:0] va);
        logic [63:0] vf;
        logic [15:0] disp;
        logic [31:0] src;
        integer n;
        disp = 16'($random(seed));
        src = $random(seed);
        vf = {$random(seed), $random(seed)};
        vf[2:0] = va;
        n = 0;
        while (instr_ready !== 1'b1 && n < 50) begin
            @(posedge clock);
            #1;
            n = n + 1;
        end
        check(instr_ready, 1'b1, "ready before issue");
        @(posedge clock);
        wait_n <= 2'($random(seed));
        instr_valid <= 1'b1;
        instr_word <= {(k == UWS_KIND_LEFT) ? `UWS_OP_LEFT : `UWS_OP_RIGHT, 10'($random(seed)), disp};
        base_value <= vf - {{48{disp[15]}}, disp};
        source_value <= {32'($random(seed)), src};
        order_in <= o;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
        check(xlat_valid, 1'b1, "translation request");
        check(xlat_virtual_byte_address, vf, "virtual address");
        n = 0;
        while (got !== 1'b1 && n < 30) begin
            @(posedge clock);
            #1;
            n = n + 1;
        end
        check(got, 1'b1, "store accepted");
        check(seen, exp_req(k, o, va, src, vf[31:0] ^ PMAP), "store request");
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        for (i = 0; i < 128; i = i + 1) begin
            run_op(uws_kind_t'(i[0]), uws_order_t'(i[6:4]), i[3:1]);
        end
        $display("Directed sweep done");
        for (i = 0; i < 200; i = i + 1) begin
            r = $random(seed);
            run_op(uws_kind_t'(r[0]), uws_order_t'(r[3:1]), r[6:4]);
        end
        $display("Random stores done");
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word <= {6'h2B, 26'h0};
        repeat (4) @(posedge clock);
        #1;
        check(xlat_valid, 1'b0, "other opcode taken");
        check(instr_ready, 1'b1, "ready after other opcode");
        @(posedge clock);
        instr_valid <= 1'b0;
        $display("Other opcode test done");
        report_and_stop;
    end
endmodule

`default_nettype wire
